// ==== src/pmt_consts.svh ====
// Purpose: offsets, field positions, reset values and timing of the timer
// Assumes: included by the prescaler, the timer and the bench by bare name
// Notes: register index equals byte offset on the plain port
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
`define PMT_ADDR_W 3
`define PMT_OFF_COUNT 3'h0
`define PMT_OFF_PERIOD 3'h1
`define PMT_OFF_CONTROL 3'h2
`define PMT_OFF_IRQ_STATUS 3'h3
`define PMT_OFF_IRQ_CLEAR 3'h4
`define PMT_OFF_IRQ_ENABLE 3'h5
`define PMT_CTL_PRE_LSB 0
`define PMT_CTL_RUN_BIT 2
`define PMT_CTL_POST_LSB 3
`define PMT_IRQ_MATCH_BIT 0
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_CONTROL 7'h00
`define PMT_INSTR_DIV 2'h3
`define PMT_PRE_DIV4_TOP 4'h3
`define PMT_PRE_DIV16_TOP 4'hf
`endif

// ==== src/pmt_pkg.sv ====
// Purpose: shared types of the period match timer
// Assumes: constants come from pmt_consts.svh
// Notes: control layout is post[6:3], run[2], pre[1:0]
package pmt_pkg;
    typedef struct packed {
        logic [3:0] post;
        logic run;
        logic [1:0] pre;
    } pmt_ctl_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } pmt_bus_t;
endpackage

// ==== src/pmt_prescale.sv ====
// Purpose: instruction clock tick and selectable prescaler
// Assumes: clk is the system oscillator
// Notes: clr restarts both dividers
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_prescale import pmt_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic clr,
    input wire logic run,
    input wire logic [1:0] pre,
    output logic tick
);
    typedef struct packed {
        logic [1:0] q4;
        logic [3:0] cnt;
        logic tick;
    } pmt_pre_st_t;
    pmt_pre_st_t s_q, s_d;
    logic [3:0] top;
    always_comb begin
        case (pre)
            2'h0: top = 4'h0;
            2'h1: top = `PMT_PRE_DIV4_TOP;
            default: top = `PMT_PRE_DIV16_TOP;
        endcase
    end
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.q4 = s_q.q4 + 2'h1;
        if (run && s_q.q4 == `PMT_INSTR_DIV) begin
            if (s_q.cnt >= top) begin
                s_d.cnt = 4'h0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
        if (clr) begin
            s_d.cnt = 4'h0;
            s_d.q4 = 2'h0;
            s_d.tick = 1'b0;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule // pmt_prescale

// ==== src/pmt_postscale.sv ====
// Purpose: 4-bit postscaler on the match pulse
// Assumes: match is a one-cycle pulse
// Notes: done pulses every post+1 matches
`timescale 1ns/100ps
module pmt_postscale import pmt_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic clr,
    input wire logic match,
    input wire logic [3:0] post,
    output logic done
);
    typedef struct packed {
        logic [3:0] cnt;
        logic done;
    } pmt_post_st_t;
    pmt_post_st_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (match) begin
            if (s_q.cnt >= post) begin
                s_d.cnt = 4'h0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
        if (clr) begin
            s_d = '0;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done = s_q.done;
endmodule // pmt_postscale

// ==== src/pmt_timer.sv ====
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: reset covers every device reset; sleep held high while asleep
// Notes: match pulse lasts one system clock per timer match
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_timer import pmt_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic sleep,
    output logic [7:0] rdata,
    output logic irq,
    output logic pwm_timebase,
    output logic spi_shift_clk
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
        pmt_ctl_t ctl;
        logic flag;
        logic ien;
        logic [7:0] rdata;
        logic irq;
        logic match;
        logic zero_next;
    } pmt_st_t;
    pmt_st_t s_q, s_d;
    pmt_bus_t bus;
    logic tick;
    logic done;
    logic scaler_clr;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        hit = (a == o);
    endfunction

    assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    // Writes to count or control restart both scalers
    assign scaler_clr = bus.wr && (hit(bus.addr, `PMT_OFF_COUNT) ||
        hit(bus.addr, `PMT_OFF_CONTROL));

    pmt_prescale u_pre (
        .clk(clk),
        .reset(reset),
        .clr(scaler_clr),
        .run(s_q.ctl.run && !sleep),
        .pre(s_q.ctl.pre),
        .tick(tick)
    );

    pmt_postscale u_post (
        .clk(clk),
        .reset(reset),
        .clr(scaler_clr),
        .match(s_q.match),
        .post(s_q.ctl.post),
        .done(done)
    );

    always_comb begin
        s_d = s_q;
        s_d.match = 1'b0;
        s_d.rdata = 8'h00;
        if (tick && !sleep) begin
            // Compare happens on each timer clock
            if (s_q.count == s_q.period) begin
                s_d.match = 1'b1;
                s_d.count = 8'h00;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end
        if (bus.wr) begin
            case (bus.addr)
                `PMT_OFF_COUNT: s_d.count = bus.wdata;
                `PMT_OFF_PERIOD: s_d.period = bus.wdata;
                // Count is left alone here on purpose
                `PMT_OFF_CONTROL: s_d.ctl = bus.wdata[6:0];
                `PMT_OFF_IRQ_CLEAR: begin
                    if (bus.wdata[`PMT_IRQ_MATCH_BIT]) begin
                        s_d.flag = 1'b0;
                    end
                end
                `PMT_OFF_IRQ_ENABLE: begin
                    s_d.ien = bus.wdata[`PMT_IRQ_MATCH_BIT];
                end
                default: begin
                end
            endcase
        end
        // Set beats a clear in the same cycle
        if (done) begin
            s_d.flag = 1'b1;
        end
        if (bus.rd) begin
            case (bus.addr)
                `PMT_OFF_COUNT: s_d.rdata = s_q.count;
                `PMT_OFF_PERIOD: s_d.rdata = s_q.period;
                `PMT_OFF_CONTROL: s_d.rdata = {1'b0, s_q.ctl};
                `PMT_OFF_IRQ_STATUS: s_d.rdata = {7'h00, s_q.flag};
                `PMT_OFF_IRQ_ENABLE: s_d.rdata = {7'h00, s_q.ien};
                default: s_d.rdata = 8'h00;
            endcase
        end
        s_d.irq = s_d.flag && s_d.ien;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.count <= `PMT_RST_COUNT;
            s_q.period <= `PMT_RST_PERIOD;
            s_q.ctl <= `PMT_RST_CONTROL;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign pwm_timebase = s_q.match;
    assign spi_shift_clk = s_q.match;

    property p_match_zero;
        @(posedge clk) disable iff (reset)
        (tick && !sleep && s_q.count == s_q.period && !bus.wr)
            |=> (s_q.count == 8'h00 && s_q.match);
    endproperty
    a_match_zero: assert property (p_match_zero)
        else $error("count not zeroed after match");

    property p_match_cause;
        @(posedge clk) disable iff (reset)
        s_q.match |-> $past(s_q.count == s_q.period && tick);
    endproperty
    a_match_cause: assert property (p_match_cause)
        else $error("match without equal compare");

    property p_ctl_keep;
        @(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == `PMT_OFF_CONTROL && !tick)
            |=> s_q.count == $past(s_q.count);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep)
        else $error("control write changed count");

    property p_sleep_hold;
        @(posedge clk) disable iff (reset)
        (sleep && !bus.wr) |=> s_q.count == $past(s_q.count);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("count moved during sleep");

    property p_stop_hold;
        @(posedge clk) disable iff (reset)
        (!s_q.ctl.run && !bus.wr) [*2] |=> s_q.count == $past(s_q.count);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("count moved while stopped");

    property p_irq_gate;
        @(posedge clk) disable iff (reset)
        irq == (s_q.flag && s_q.ien);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without enabled flag");

    property p_flag_set;
        @(posedge clk) disable iff (reset)
        done |=> s_q.flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set on postscaler completion");

    property p_count_wr;
        @(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == `PMT_OFF_COUNT)
            |=> s_q.count == $past(bus.wdata) ##1 !tick;
    endproperty
    a_count_wr: assert property (p_count_wr)
        else $error("count write lost");

    property p_rd;
        @(posedge clk) disable iff (reset)
        (bus.rd && bus.addr == `PMT_OFF_PERIOD) |=> rdata == $past(s_q.period);
    endproperty
    a_rd: assert property (p_rd)
        else $error("period read wrong");

    property p_pre16;
        @(posedge clk) disable iff (reset)
        (tick && s_q.ctl.pre[1] && s_q.ctl.run && !sleep)
            |=> !tick [*8];
    endproperty
    a_pre16: assert property (p_pre16)
        else $error("prescale by sixteen ticked early");

    property p_rst_vals;
        @(posedge clk)
        $fell(reset) |-> (s_q.period == `PMT_RST_PERIOD &&
            s_q.count == `PMT_RST_COUNT);
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("count or period wrong after reset");

    // Shorthand for cycles in which nothing disturbs the prescaler
    logic quiet;
    assign quiet = s_q.ctl.run && !sleep && !bus.wr;

    property p_inst_rate;
        @(posedge clk) disable iff (reset)
        (tick && s_q.ctl.pre == 2'h0 && !bus.wr) ##1 quiet [*3] |=> tick;
    endproperty
    a_inst_rate: assert property (p_inst_rate)
        else $error("instruction rate tick missing");

    property p_pre4_rate;
        @(posedge clk) disable iff (reset)
        (tick && s_q.ctl.pre == 2'h1 && !bus.wr) ##1 quiet [*8]
            ##1 quiet [*7] |=> tick;
    endproperty
    a_pre4_rate: assert property (p_pre4_rate)
        else $error("prescale by four tick missing");

    property p_pre4_gap;
        @(posedge clk) disable iff (reset)
        (tick && s_q.ctl.pre == 2'h1) |-> ##4 !tick;
    endproperty
    a_pre4_gap: assert property (p_pre4_gap)
        else $error("prescale by four ticked early");

    property p_clr_restart;
        @(posedge clk) disable iff (reset)
        scaler_clr |=> (!tick && !done) ##1 !tick [*3];
    endproperty
    a_clr_restart: assert property (p_clr_restart)
        else $error("scalers not restarted");

    property p_post_one;
        @(posedge clk) disable iff (reset)
        (s_q.match && s_q.ctl.post == 4'h0 && !scaler_clr) |=> done;
    endproperty
    a_post_one: assert property (p_post_one)
        else $error("postscale one to one missed a match");

    property p_post_gap;
        @(posedge clk) disable iff (reset)
        (done && s_q.ctl.post != 4'h0) |=> !done [*6];
    endproperty
    a_post_gap: assert property (p_post_gap)
        else $error("postscaler completed too soon");

    property p_flag_hold;
        @(posedge clk) disable iff (reset)
        (s_q.flag && !(bus.wr && bus.addr == `PMT_OFF_IRQ_CLEAR))
            |=> s_q.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without clear");

    property p_flag_clear;
        @(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == `PMT_OFF_IRQ_CLEAR &&
            bus.wdata[`PMT_IRQ_MATCH_BIT] && !done) |=> !s_q.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared");

    property p_irq_on;
        @(posedge clk) disable iff (reset)
        (done && s_q.ien && !(bus.wr && bus.addr == `PMT_OFF_IRQ_ENABLE))
            |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled flag raised no irq");

    property p_irq_off;
        @(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == `PMT_OFF_IRQ_ENABLE &&
            !bus.wdata[`PMT_IRQ_MATCH_BIT]) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq while disabled");

    property p_pulse_one;
        @(posedge clk) disable iff (reset)
        pwm_timebase |-> spi_shift_clk ##1 !pwm_timebase;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("match pulse not a single cycle");

    property p_sleep_quiet;
        @(posedge clk) disable iff (reset)
        sleep |=> !tick && !pwm_timebase;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("timer ticked during sleep");

    property p_stop_tick;
        @(posedge clk) disable iff (reset)
        !s_q.ctl.run |=> !tick;
    endproperty
    a_stop_tick: assert property (p_stop_tick)
        else $error("tick while stopped");

    property p_count_step;
        @(posedge clk) disable iff (reset)
        (tick && !sleep && s_q.count != s_q.period && !bus.wr)
            |=> (s_q.count == $past(s_q.count) + 8'h01) && !s_q.match;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count did not step by one");

    property p_period_wr;
        @(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == `PMT_OFF_PERIOD)
            |=> s_q.period == $past(bus.wdata);
    endproperty
    a_period_wr: assert property (p_period_wr)
        else $error("period write lost");

    property p_rd_count;
        @(posedge clk) disable iff (reset)
        (bus.rd && bus.addr == `PMT_OFF_COUNT)
            |=> rdata == $past(s_q.count);
    endproperty
    a_rd_count: assert property (p_rd_count)
        else $error("count read wrong");

    property p_rdata_idle;
        @(posedge clk) disable iff (reset)
        !bus.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
endmodule // pmt_timer

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the period match timer
// Assumes: design files compiled first, consts header on the include path
// Notes: no partner model; the bench drives the register port itself
`timescale 1ns/100ps
`include "pmt_consts.svh"
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic pwm_timebase;
    logic spi_shift_clk;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    pmt_timer u_dut (
        .clk(clk),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .sleep(sleep),
        .rdata(rdata),
        .irq(irq),
        .pwm_timebase(pwm_timebase),
        .spi_shift_clk(spi_shift_clk)
    );

    always #20 clk = ~clk;

    // Whole run needs well under this; a hang ends up here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] ctl(input logic [3:0] p, input logic r,
                                       input logic [1:0] s);
        return {1'b0, p, r, s};
    endfunction

    // Entered and left just after a rising edge
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // One idle edge keeps two writes from sharing a time step
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        logic [2:0] offs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
        logic [7:0] exps [6] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
        foreach (offs[i]) begin
            rd_reg(offs[i], v);
            chk("reset value", v, exps[i]);
        end
        wr_reg(`PMT_OFF_COUNT, 8'h5a);
        wr_reg(`PMT_OFF_PERIOD, 8'ha5);
        wr_reg(`PMT_OFF_IRQ_STATUS, 8'hff);
        rd_reg(`PMT_OFF_COUNT, v);
        chk("count", v, 8'h5a);
        rd_reg(`PMT_OFF_PERIOD, v);
        chk("period", v, 8'ha5);
        rd_reg(`PMT_OFF_IRQ_STATUS, v);
        chk("status", v, 8'h00);
        $display("test reset done");
    endtask

    // Cycles between two match pulses, the first interval may be partial
    task automatic gap(output int n);
        n = 0;
        repeat (500) begin
            @(negedge clk);
            if (pwm_timebase === 1'b1) break;
        end
        repeat (500) begin
            @(negedge clk);
            n++;
            if (pwm_timebase === 1'b1) break;
        end
        chk("shift_clk", spi_shift_clk, pwm_timebase);
        @(posedge clk);
    endtask

    task automatic t_rate();
        int n;
        int div [4] = '{1, 4, 16, 16};
        wr_reg(`PMT_OFF_PERIOD, 8'h02);
        // A count left above the period would wrap first and take too long
        wr_reg(`PMT_OFF_COUNT, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b1, i[1:0]));
            gap(n);
            chk("interval", n[7:0], 8'(12 * div[i]));
        end
        $display("test rate done");
    endtask

    task automatic t_post();
        int n;
        logic [7:0] v;
        logic [3:0] ns [3] = '{4'h0, 4'h3, 4'hf};
        foreach (ns[j]) begin
            wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b0, 2'h0));
            wr_reg(`PMT_OFF_IRQ_CLEAR, 8'h01);
            wr_reg(`PMT_OFF_PERIOD, 8'h01);
            wr_reg(`PMT_OFF_IRQ_ENABLE, 8'h01);
            wr_reg(`PMT_OFF_CONTROL, ctl(ns[j], 1'b1, 2'h0));
            n = 0;
            repeat (600) begin
                @(negedge clk);
                if (irq === 1'b1) break;
                if (pwm_timebase === 1'b1) n++;
            end
            @(posedge clk);
            chk("matches", n[7:0], 8'(ns[j] + 1));
            wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b0, 2'h0));
            wr_reg(`PMT_OFF_IRQ_ENABLE, 8'h00);
            repeat (2) @(negedge clk);
            chk("irq masked", irq, 1'b0);
            @(posedge clk);
            rd_reg(`PMT_OFF_IRQ_STATUS, v);
            chk("flag sticky", v, 8'h01);
            wr_reg(`PMT_OFF_IRQ_CLEAR, 8'h01);
            rd_reg(`PMT_OFF_IRQ_STATUS, v);
            chk("flag cleared", v, 8'h00);
        end
        $display("test postscale done");
    endtask

    task automatic t_hold();
        logic [7:0] a;
        logic [7:0] b;
        wr_reg(`PMT_OFF_PERIOD, 8'hff);
        wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b1, 2'h0));
        repeat (60) @(posedge clk);
        wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b0, 2'h0));
        rd_reg(`PMT_OFF_COUNT, a);
        chk("count ran", 8'(a == 8'h00), 8'h00);
        wr_reg(`PMT_OFF_CONTROL, ctl(4'h5, 1'b0, 2'h1));
        repeat (40) @(posedge clk);
        rd_reg(`PMT_OFF_COUNT, b);
        chk("count kept", b, a);
        sleep <= 1'b1;
        wr_reg(`PMT_OFF_CONTROL, ctl(4'h0, 1'b1, 2'h0));
        repeat (40) @(posedge clk);
        rd_reg(`PMT_OFF_COUNT, b);
        chk("count asleep", b, a);
        rd_reg(`PMT_OFF_PERIOD, b);
        chk("period asleep", b, 8'hff);
        sleep <= 1'b0;
        repeat (40) @(posedge clk);
        rd_reg(`PMT_OFF_COUNT, b);
        chk("count awake", 8'(b == a), 8'h00);
        $display("test hold done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_rate();
        t_post();
        t_hold();
        end_sim();
    end
endmodule // tb_top
